// ### core/tcs_consts.vh
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// register indices on the avalon bus (byte address is register index times four)
`define TCS_IDX_CTRL       16'h2000
`define TCS_IDX_STATUS     16'h2002
`define TCS_IDX_BASE_A     16'h2010
`define TCS_IDX_FEND_A     16'h2012
`define TCS_IDX_RATIO_A    16'h2014
`define TCS_IDX_BASE_B     16'h2020
`define TCS_IDX_FEND_B     16'h2022
`define TCS_IDX_RATIO_B    16'h2024
`define TCS_IDX_BASE_C     16'h2030
`define TCS_IDX_FEND_C     16'h2032
`define TCS_IDX_RATIO_C    16'h2034
`define TCS_IDX_EVENTS     16'h2060
`define TCS_AW             18

// status register fields
`define TCS_ST_OVR         5
`define TCS_ST_ERR         6
`define TCS_ST_SERV        15

// control register fields
`define TCS_CT_RUN_A       0
`define TCS_CT_RUN_B       1
`define TCS_CT_RUN_C       2
`define TCS_CT_OVR_IE      5
`define TCS_CT_ERR_IE      6
`define TCS_CT_MASK        16'h0067

// base register fields
`define TCS_BASE_MSB       11
`define TCS_ENT_MSB        15
`define TCS_ENT_LSB        12
`define TCS_ENT_8          4'h0
`define TCS_ENT_16         4'h1
`define TCS_ENT_32         4'h2
`define TCS_LOW_ZERO       9'h000

// ratio register fields
`define TCS_RT_MASK        16'h000f
`define TCS_RT_SINGLE      3
`define TCS_INIT_MSB       7
`define TCS_INIT_LSB       6
`define TCS_FRAMES_SINGLE  3'h1
`define TCS_FRAMES_MULTI   3'h4

// event register fields (write-one pulses)
`define TCS_EV_ERR         0
`define TCS_EV_OVR         1

`define TCS_ZERO16         16'h0000

`endif

// ### core/tcs_regs.v
`timescale 1ns/1ns
`include "tcs_consts.vh"

// Functional notes
// RQ1: overload error sets sticky status bit six
// RQ2: write one clears overload flag
// RQ3: host stops, rebalances, reinitialises after overload
// RQ4: service flag follows overrun or overload
// RQ5: status bits fourteen to seven read zero
// RQ6: base field gives address bits twenty:nine
// RQ7: entries code selects eight, sixteen, thirty-two
// RQ8: host keeps config stable while enabled
// RQ9: short end frame bounds short turn
// RQ10: long end frame bounds long turn
// RQ11: ratio gives long turns per short
// RQ12: host programs ratio zero, one, three, seven
// RQ13: single bit picks one or four frames
// RQ14: host clears single bit at full load
// RQ15: host writes zero to reserved ratio bits
// RQ16: host writes packet init codes per scheduler
// RQ17: separate end-frame and ratio registers per scheduler
// RQ18: overload with enable raises global service
// RQ19: scheduler runs only while enable set
// RQ20: overrun latches when write meets read pointer
// RQ21: service flag falls when both cleared
module tcs_regs (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // avalon-mm slave
  input  wire [17:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  // engine events
  input  wire        overload_evt,
  input  wire        overrun_evt,
  // scheduler controls
  output reg  [2:0]  sched_run_ff,
  output reg         global_tx_service_flag,
  output reg  [20:0] table_base_addr_a,
  output reg  [20:0] table_base_addr_b,
  output reg  [20:0] table_base_addr_c,
  output reg  [5:0]  entries_per_frame_a,
  output reg  [5:0]  entries_per_frame_b,
  output reg  [5:0]  entries_per_frame_c,
  output reg  [47:0] end_frames_ff,
  output reg  [8:0]  long_per_short_ff,
  output reg  [8:0]  frames_per_pass_ff,
  output reg  [5:0]  packet_mode_init_code
);

  // register storage
  reg  [15:0] ctrl_ff;
  reg         err_ff;
  reg         ovr_ff;
  reg  [15:0] base_ff [0:2];
  reg  [15:0] fend_ff [0:2];
  reg  [15:0] ratio_ff [0:2];
  reg  [1:0]  init_ff [0:2];
  reg         ack_ff;
  reg  [15:0] nxt_rdata;
  reg         nxt_hit;
  integer     i;

  wire [15:0] wdata = avs_writedata[15:0];
  wire        lane0 = avs_byteenable[0];
  wire        lane1 = avs_byteenable[1];
  // a write lands only at the edge where the master sees waitrequest low
  wire        wr_go = avs_write & ~avs_waitrequest;
  wire [15:0] wmask = {{8{lane1}}, {8{lane0}}};
  wire [15:0] reg_idx = avs_address[17:2];
  wire [15:0] status_word = {ovr_ff | err_ff, 8'h00, err_ff, ovr_ff, 5'h00};  // [RQ4] [RQ5]

  // entries per frame from the code, reserved codes map to zero
  function [5:0] ent_count;
    input [3:0] code;
    begin
      case (code)
        `TCS_ENT_8:  ent_count = 6'h08;   // [RQ7]
        `TCS_ENT_16: ent_count = 6'h10;
        `TCS_ENT_32: ent_count = 6'h20;
        default:     ent_count = 6'h00;
      endcase
    end
  endfunction

  // base field to 21-bit memory address, low bits forced zero
  function [20:0] base_addr;
    input [15:0] r;
    begin
      base_addr = {r[`TCS_BASE_MSB:0], `TCS_LOW_ZERO};  // [RQ6]
    end
  endfunction

  // frames assembled per pass from a ratio register
  function [2:0] frames_of;
    input [15:0] r;
    begin
      frames_of = r[`TCS_RT_SINGLE] ? `TCS_FRAMES_SINGLE : `TCS_FRAMES_MULTI;  // [RQ13]
    end
  endfunction

  // which scheduler index, 3 for none
  function [1:0] sched_of;
    input [15:0] a;
    input [15:0] b0;
    begin
      if (a == b0)
        sched_of = 2'h0;
      else if (a == b0 + 16'h0010)
        sched_of = 2'h1;
      else if (a == b0 + 16'h0020)
        sched_of = 2'h2;
      else
        sched_of = 2'h3;
    end
  endfunction

  // read decode
  always @* begin
    nxt_rdata = `TCS_ZERO16;
    nxt_hit   = 1'b1;
    if (reg_idx == `TCS_IDX_CTRL)
      nxt_rdata = ctrl_ff;
    else if (reg_idx == `TCS_IDX_STATUS)
      nxt_rdata = status_word;
    else if (reg_idx == `TCS_IDX_EVENTS)
      nxt_rdata = `TCS_ZERO16;
    else if (sched_of(reg_idx, `TCS_IDX_BASE_A) != 2'h3)
      nxt_rdata = base_ff[sched_of(reg_idx, `TCS_IDX_BASE_A)];
    else if (sched_of(reg_idx, `TCS_IDX_FEND_A) != 2'h3)
      nxt_rdata = fend_ff[sched_of(reg_idx, `TCS_IDX_FEND_A)];  // [RQ17]
    else if (sched_of(reg_idx, `TCS_IDX_RATIO_A) != 2'h3)
      nxt_rdata = ratio_ff[sched_of(reg_idx, `TCS_IDX_RATIO_A)]; // init bits are write-only
    else
      nxt_hit = 1'b0;
  end

  // bus handshake: one wait cycle, then ack; ack blocks a repeat of the same access
  always @(posedge clock) begin
    if (!reset_n) begin
      ack_ff          <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'h0;
    end else begin
      ack_ff          <= (avs_read | avs_write) & ~ack_ff;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_ff);
      avs_readdata    <= {16'h0000, nxt_rdata};
      avs_response    <= nxt_hit ? 2'h0 : 2'h2;  // slverr on unmapped
    end
  end

  // register writes and sticky flags
  always @(posedge clock) begin
    if (!reset_n) begin
      ctrl_ff <= `TCS_ZERO16;
      err_ff  <= 1'b0;
      ovr_ff  <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        base_ff[i]  <= `TCS_ZERO16;
        fend_ff[i]  <= `TCS_ZERO16;
        ratio_ff[i] <= `TCS_ZERO16;
        init_ff[i]  <= 2'h0;
      end
    end else begin
      // set wins over a clear in the same cycle
      if (overload_evt | (wr_go & lane0 & reg_idx == `TCS_IDX_EVENTS & wdata[`TCS_EV_ERR]))
        err_ff <= 1'b1;                                                  // [RQ1]
      else if (wr_go & lane0 & reg_idx == `TCS_IDX_STATUS & wdata[`TCS_ST_ERR])
        err_ff <= 1'b0;                                                  // [RQ2] [RQ21]
      if (overrun_evt | (wr_go & lane0 & reg_idx == `TCS_IDX_EVENTS & wdata[`TCS_EV_OVR]))
        ovr_ff <= 1'b1;                                                  // [RQ20]
      else if (wr_go & lane0 & reg_idx == `TCS_IDX_STATUS & wdata[`TCS_ST_OVR])
        ovr_ff <= 1'b0;                                                  // [RQ21]
      if (wr_go & reg_idx == `TCS_IDX_CTRL)
        ctrl_ff <= ((ctrl_ff & ~wmask) | (wdata & wmask)) & `TCS_CT_MASK;
      // configuration is taken as written; keeping it still while running is host duty [RQ8]
      if (wr_go & sched_of(reg_idx, `TCS_IDX_BASE_A) != 2'h3)
        base_ff[sched_of(reg_idx, `TCS_IDX_BASE_A)] <=
          (base_ff[sched_of(reg_idx, `TCS_IDX_BASE_A)] & ~wmask) | (wdata & wmask);
      if (wr_go & sched_of(reg_idx, `TCS_IDX_FEND_A) != 2'h3)
        fend_ff[sched_of(reg_idx, `TCS_IDX_FEND_A)] <=
          (fend_ff[sched_of(reg_idx, `TCS_IDX_FEND_A)] & ~wmask) | (wdata & wmask);
      if (wr_go & lane0 & sched_of(reg_idx, `TCS_IDX_RATIO_A) != 2'h3) begin
        ratio_ff[sched_of(reg_idx, `TCS_IDX_RATIO_A)] <= wdata & `TCS_RT_MASK;
        init_ff[sched_of(reg_idx, `TCS_IDX_RATIO_A)]  <= wdata[`TCS_INIT_MSB:`TCS_INIT_LSB];
      end
    end
  end

  // decoded scheduler settings, registered so outputs come from flops
  always @(posedge clock) begin
    if (!reset_n) begin
      sched_run_ff           <= 3'h0;
      global_tx_service_flag <= 1'b0;
      table_base_addr_a      <= 21'h000000;
      table_base_addr_b      <= 21'h000000;
      table_base_addr_c      <= 21'h000000;
      entries_per_frame_a    <= 6'h00;
      entries_per_frame_b    <= 6'h00;
      entries_per_frame_c    <= 6'h00;
      end_frames_ff          <= 48'h000000000000;
      long_per_short_ff      <= 9'h000;
      frames_per_pass_ff     <= 9'h000;
      packet_mode_init_code  <= 6'h00;
    end else begin
      sched_run_ff <= {ctrl_ff[`TCS_CT_RUN_C], ctrl_ff[`TCS_CT_RUN_B],
                       ctrl_ff[`TCS_CT_RUN_A]};                          // [RQ19]
      global_tx_service_flag <= (err_ff & ctrl_ff[`TCS_CT_ERR_IE]) |
                                (ovr_ff & ctrl_ff[`TCS_CT_OVR_IE]);      // [RQ18]
      table_base_addr_a   <= base_addr(base_ff[0]);
      table_base_addr_b   <= base_addr(base_ff[1]);
      table_base_addr_c   <= base_addr(base_ff[2]);
      entries_per_frame_a <= ent_count(base_ff[0][`TCS_ENT_MSB:`TCS_ENT_LSB]);
      entries_per_frame_b <= ent_count(base_ff[1][`TCS_ENT_MSB:`TCS_ENT_LSB]);
      entries_per_frame_c <= ent_count(base_ff[2][`TCS_ENT_MSB:`TCS_ENT_LSB]);
      // per scheduler: {long_turn_last_frame, short_turn_last_frame}
      end_frames_ff <= {fend_ff[2], fend_ff[1], fend_ff[0]};            // [RQ9] [RQ10]
      long_per_short_ff <= {ratio_ff[2][2:0], ratio_ff[1][2:0], ratio_ff[0][2:0]}; // [RQ11]
      frames_per_pass_ff <= {frames_of(ratio_ff[2]), frames_of(ratio_ff[1]),
                             frames_of(ratio_ff[0])};                    // [RQ13]
      packet_mode_init_code <= {init_ff[2], init_ff[1], init_ff[0]};
    end
  end

endmodule

// ### test/tcs_regs_props.sv
`timescale 1ns/1ns
`include "tcs_consts.vh"
module tcs_regs_props (
  // clock and reset
  input logic        clock,
  input logic        reset_n,
  // register bus
  input logic [17:0] avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  // derived controls
  input logic [2:0]  sched_run_ff,
  input logic [20:0] table_base_addr_a,
  input logic [5:0]  entries_per_frame_a,
  input logic [47:0] end_frames_ff,
  input logic [8:0]  long_per_short_ff,
  input logic [8:0]  frames_per_pass_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // accepted transfers; outputs lag the register by one more edge, hence ##2
  wire [15:0] idx = avs_address[17:2];
  wire        wr  = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire        wr2 = wr && avs_byteenable[1];
  wire        rd  = avs_read && !avs_waitrequest && idx == `TCS_IDX_STATUS;
  property p_rsvd; rd |-> avs_readdata[14:7] == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
  property p_serv; rd |-> avs_readdata[15] == |avs_readdata[6:5]; endproperty
  a_serv: assert property (p_serv) else $error("summary flag wrong");
  property p_base;
    wr2 && idx == `TCS_IDX_BASE_A |->
      ##2 table_base_addr_a == {$past(avs_writedata[11:0], 2), 9'h000};
  endproperty
  a_base: assert property (p_base) else $error("base address wrong");
  property p_ent;
    wr2 && idx == `TCS_IDX_BASE_A && avs_writedata[15:12] <= 4'h2 |->
      ##2 entries_per_frame_a == 6'h08 << $past(avs_writedata[13:12], 2);
  endproperty
  a_ent: assert property (p_ent) else $error("entries wrong");
  property p_run; wr && idx == `TCS_IDX_CTRL |-> ##2 sched_run_ff == $past(avs_writedata[2:0], 2);
  endproperty
  a_run: assert property (p_run) else $error("run enables wrong");
  property p_fend;
    wr2 && idx == `TCS_IDX_FEND_C |-> ##2 end_frames_ff[47:32] == $past(avs_writedata[15:0], 2);
  endproperty
  a_fend: assert property (p_fend) else $error("end frames wrong");
  property p_ratio;
    wr && idx == `TCS_IDX_RATIO_B |-> ##2 long_per_short_ff[5:3] == $past(avs_writedata[2:0], 2);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_single;
    wr && idx == `TCS_IDX_RATIO_A |->
      ##2 frames_per_pass_ff[2:0] == ($past(avs_writedata[3], 2) ? 3'h1 : 3'h4);
  endproperty
  a_single: assert property (p_single) else $error("frames per pass wrong");
  // main scenarios reached
  c_rd: cover property (rd && avs_readdata[6]);
  c_ctl: cover property (wr && idx == `TCS_IDX_CTRL);
  c_base: cover property (wr2 && idx == `TCS_IDX_BASE_A);
endmodule
bind tcs_regs tcs_regs_props u_props (.*);

// ### test/tb_top.sv
`timescale 1ns/1ns
`include "tcs_consts.vh"
module tb_top;
  logic        clock = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        overload_evt = 1'b0, overrun_evt = 1'b0, avs_waitrequest, global_tx_service_flag;
  logic [17:0] avs_address = 18'h00000;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [1:0]  avs_response, rsp, s;
  logic [2:0]  sched_run_ff;
  logic [20:0] table_base_addr_a, table_base_addr_b, table_base_addr_c;
  logic [5:0]  entries_per_frame_a, entries_per_frame_b, entries_per_frame_c, packet_mode_init_code;
  logic [47:0] end_frames_ff;
  logic [8:0]  long_per_short_ff, frames_per_pass_ff;
  logic [15:0] rdv, o, f;
  logic [3:0]  r;
  int          errors = 0, comparisons = 0, cyc = 0;
  tcs_regs DUT (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .overload_evt(overload_evt), .overrun_evt(overrun_evt), .sched_run_ff(sched_run_ff),
    .global_tx_service_flag(global_tx_service_flag), .table_base_addr_a(table_base_addr_a),
    .table_base_addr_b(table_base_addr_b), .table_base_addr_c(table_base_addr_c),
    .entries_per_frame_a(entries_per_frame_a), .entries_per_frame_b(entries_per_frame_b),
    .entries_per_frame_c(entries_per_frame_c), .end_frames_ff(end_frames_ff),
    .long_per_short_ff(long_per_short_ff), .frames_per_pass_ff(frames_per_pass_ff),
    .packet_mode_init_code(packet_mode_init_code));
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [15:0] i, input logic [15:0] d, input logic [3:0] be);
    avs_address <= {i, 2'b00};
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata[15:0];
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [15:0] i, input logic [15:0] e);
    bus(1'b0, i, 16'h0000, 4'h3);
    chk(rdv, e);
  endtask
  // one-cycle engine event: overload when ovl is high, else overrun
  task automatic pulse(input logic ovl);
    overload_evt <= ovl;
    overrun_evt <= !ovl;
    @(posedge clock);
    overload_evt <= 1'b0;
    overrun_evt <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    forever #4 clock = ~clock;
  end
  // hang guard, far above the hundred or so cycles the sequence needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rchk(`TCS_IDX_STATUS, 16'h0000);
    // per scheduler: ratio 1/3/7, single on A and C, init code A=1 B=2 C=3
    for (int k = 0; k < 6; k++) begin
      s = k % 3;
      o = 16'h0010 * s;
      f = 16'h2005 + 16'h0101 * s;
      r = {s != 2'h1, s[1], |s, 1'b1};
      if (k < 3) begin
        rchk(`TCS_IDX_FEND_A + o, 16'h0000);
        bus(1'b1, `TCS_IDX_FEND_A + o, f, 4'h3);
        bus(1'b1, `TCS_IDX_RATIO_A + o, {8'h00, s + 2'h1, 2'b00, r}, 4'h1);
        bus(1'b1, `TCS_IDX_BASE_A + o, {2'b00, s, 12'h9a0 + {10'h000, s}}, 4'h3);
      end else begin
        rchk(`TCS_IDX_FEND_A + o, f);
        rchk(`TCS_IDX_RATIO_A + o, {12'h000, r});
        chk(end_frames_ff[16 * s +: 16], f);
        chk(long_per_short_ff[3 * s +: 3], r[2:0]);
        chk(frames_per_pass_ff[3 * s +: 3], r[3] ? 3'h1 : 3'h4);
        chk(packet_mode_init_code[2 * s +: 2], s + 2'h1);
      end
    end
    chk({table_base_addr_c, table_base_addr_b, table_base_addr_a},
        {12'h9a2, 9'h000, 12'h9a1, 9'h000, 12'h9a0, 9'h000});
    chk({entries_per_frame_c, entries_per_frame_b, entries_per_frame_a}, 18'h20408);
    // overload raises the sticky flag; only a written one clears it
    bus(1'b1, `TCS_IDX_CTRL, 16'h0045, 4'h3);
    pulse(1'b1);
    rchk(`TCS_IDX_STATUS, 16'h8040);
    chk(sched_run_ff, 3'h5);
    chk(global_tx_service_flag, 1'b1);
    bus(1'b1, `TCS_IDX_CTRL, 16'h0040, 4'h3);
    bus(1'b1, `TCS_IDX_STATUS, 16'hffbf, 4'h3);
    rchk(`TCS_IDX_STATUS, 16'h8040);
    pulse(1'b0);
    rchk(`TCS_IDX_STATUS, 16'h8060);
    bus(1'b1, `TCS_IDX_STATUS, 16'h0040, 4'h3);
    rchk(`TCS_IDX_STATUS, 16'h8020);
    chk(global_tx_service_flag, 1'b0);
    bus(1'b1, `TCS_IDX_STATUS, 16'h0020, 4'h3);
    rchk(`TCS_IDX_STATUS, 16'h0000);
    // unmapped place answers with an error and zero data
    rchk(16'h2070, 16'h0000);
    chk(rsp, 2'b10);
    stop_test();
  end
endmodule
